// file: verilog/clk_prescale_consts.vh
// Purpose: Shared constants for the system clock prescaler control block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef CLK_PRESCALE_CONSTS_VH
`define CLK_PRESCALE_CONSTS_VH

// Register byte offsets
`define OFS_OSC_TRIM        6'h00
`define OFS_CLOCK_DIV_CTRL  6'h04
`define OFS_CLOCK_CONFIG    6'h08
`define OFS_CLOCK_STATUS    6'h0C

// Field positions in the divide control register
`define UNLOCK_BIT          7
`define SELECT_MSB          3
`define SELECT_LSB          0

// Field positions in the config register
`define EXT_TCLK_BIT        0

// Field positions in the status register
`define ST_UNLOCK_BIT       0
`define ST_SWITCHING_BIT    1
`define ST_TOSC_OK_BIT      2

// Reset values and largest valid code of the select field
`define SELECT_RST_DIV1     4'h0
`define SELECT_RST_DIV8     4'h3
`define SELECT_MAX          4'h8

// Unlock window length in clock cycles
`define UNLOCK_CYCLES       3'h4

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: verilog/ripple_divider.v
// Purpose: Divider counter with glitch-free factor switching
// Assumes: Runs on the undivided source clock, synchronous active-low reset
// Notes:   Counter state is not visible to software
`timescale 1ns/1ps

module ripple_divider
(
    input  wire       aclk,       // Undivided source clock
    input  wire       aresetn,    // Synchronous reset, active low
    input  wire [3:0] sel,        // Requested select code, 0..8
    output reg        clk_en_q,   // One-cycle pulse per divided period
    output reg        clk_div_q,  // Divided clock level
    output reg        busy_q      // High while a factor change settles
);

    reg [7:0] count_q;            // Free running counter
    reg [3:0] cur_sel_q;          // Factor currently in effect
    reg [3:0] pend_sel_q;         // Factor waiting to take effect
    reg [1:0] edges_q;            // Period ends left before busy clears

    // Mask giving the terminal count for a code
    function [7:0] term_mask;
        input [3:0] code;
        begin
            term_mask = (8'h01 << code[2:0]) - 8'h01;
            if (code[3])
            begin
                term_mask = 8'hFF;
            end
        end
    endfunction

    wire wrap = ((count_q & term_mask(cur_sel_q)) == term_mask(cur_sel_q));

    // Counter, output clock and switch sequencing
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_q    <= 8'h00;
            cur_sel_q  <= 4'h0;
            pend_sel_q <= 4'h0;
            edges_q    <= 2'h0;
            clk_en_q   <= 1'b0;
            clk_div_q  <= 1'b0;
            busy_q     <= 1'b0;
        end
        else
        begin
            count_q  <= count_q + 8'h01;
            clk_en_q <= wrap;
            // Divided clock high in the first half of each period
            if (wrap)
            begin
                clk_div_q <= 1'b1;
            end
            else if ((count_q & term_mask(cur_sel_q)) ==
                     (term_mask(cur_sel_q) >> 1))
            begin
                clk_div_q <= (cur_sel_q == 4'h0);
            end
            // New request: let the old period finish, then one full new period
            if (sel != pend_sel_q)
            begin
                pend_sel_q <= sel;
                edges_q    <= 2'h2;
                busy_q     <= 1'b1;
            end
            else if (wrap && busy_q)
            begin
                // Switch only at a period boundary, so no short pulse
                cur_sel_q <= pend_sel_q;
                count_q   <= 8'h00;
                if (edges_q != 2'h0)
                begin
                    edges_q <= edges_q - 2'h1;
                end
                if (edges_q == 2'h1)
                begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

endmodule // ripple_divider

// file: verilog/system_clock_prescaler_ctrl.v
// Purpose: System clock prescaler control with oscillator trim and clock out
// Assumes: AXI4-Lite register slave on aclk; fuses and pins sampled
// Notes:   Divided clock leaves as an enable pulse plus a level for the pin
`timescale 1ns/1ps
`include "clk_prescale_consts.vh"

module system_clock_prescaler_ctrl
(
    input  wire        aclk,                        // System source clock
    input  wire        aresetn,                     // Synchronous reset, active low
    input  wire [5:0]  s_axi_awaddr,                // Write address
    input  wire        s_axi_awvalid,               // Write address valid
    output reg         s_axi_awready,               // Write address ready
    input  wire [31:0] s_axi_wdata,                 // Write data
    input  wire [3:0]  s_axi_wstrb,                 // Write byte strobes
    input  wire        s_axi_wvalid,                // Write data valid
    output reg         s_axi_wready,                // Write data ready
    output reg  [1:0]  s_axi_bresp,                 // Write response
    output reg         s_axi_bvalid,                // Write response valid
    input  wire        s_axi_bready,                // Write response ready
    input  wire [5:0]  s_axi_araddr,                // Read address
    input  wire        s_axi_arvalid,               // Read address valid
    output reg         s_axi_arready,               // Read address ready
    output reg  [31:0] s_axi_rdata,                 // Read data
    output reg  [1:0]  s_axi_rresp,                 // Read response
    output reg         s_axi_rvalid,                // Read data valid
    input  wire        s_axi_rready,                // Read data ready
    input  wire        clock_pin_drive_fuse,        // Clock-out fuse programmed
    input  wire        divide_by_eight_fuse,        // Start divided by eight
    input  wire [7:0]  factory_trim,                // Stored calibration byte
    input  wire        internal_rc_selected,        // Internal RC is the source
    input  wire        port_pin_out,                // Ordinary port drive value
    input  wire        port_pin_oe,                 // Ordinary port drive enable
    output reg         clock_output_pin_o,          // Pin output value
    output reg         clock_output_pin_oe,         // Pin output enable
    output reg         sys_clk_en,                  // CPU/flash/IO/ADC clock enable
    output reg  [7:0]  osc_trim_o,                  // Trim to the RC oscillator
    output reg         timer_osc_enable,            // Timer oscillator allowed
    output reg         external_timer_clock_select  // External clock on timer pin
);

    reg  [7:0] osc_trim_q;            // Oscillator trim register
    reg  [3:0] divide_select_q;       // Division select field
    reg        divide_change_unlock_q;// Unlock bit
    reg  [2:0] unlock_cnt_q;          // Cycles left in unlock window
    reg        ext_tclk_q;            // External timer clock select
    reg        fuse_s1_q;             // Fuse synchroniser stage 1
    reg        fuse_s2_q;             // Fuse synchroniser stage 2
    reg        fuse_s3_q;             // Fuse synchroniser stage 3
    reg        fuse_q;                // Filtered clock-out fuse
    reg        rst_seen_q;            // Reset-time loads done
    reg        aw_hold_q;             // Write address captured
    reg        w_hold_q;              // Write data captured
    reg  [5:0] aw_addr_q;             // Captured write address
    reg  [31:0] w_data_q;             // Captured write data
    reg  [3:0] w_strb_q;              // Captured write strobes

    wire       div_en;                // Divided clock enable pulse
    wire       div_level;             // Divided clock level
    wire       div_busy;              // Factor change in progress

    // Divider on the raw source clock
    ripple_divider u_div
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .sel       (divide_select_q),
        .clk_en_q  (div_en),
        .clk_div_q (div_level),
        .busy_q    (div_busy)
    );

    // True for a select code that has a defined factor
    function sel_valid;
        input [3:0] code;
        begin
            sel_valid = (code <= `SELECT_MAX);
        end
    endfunction

    // Write decode helpers
    wire wr_fire   = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire wr_ctrl   = wr_fire && (aw_addr_q[5:2] == `OFS_CLOCK_DIV_CTRL >> 2)
                     && w_strb_q[0];
    wire wr_trim   = wr_fire && (aw_addr_q[5:2] == `OFS_OSC_TRIM >> 2)
                     && w_strb_q[0];
    wire wr_cfg    = wr_fire && (aw_addr_q[5:2] == `OFS_CLOCK_CONFIG >> 2)
                     && w_strb_q[0];
    wire wr_known  = (aw_addr_q[5:2] == `OFS_OSC_TRIM >> 2) ||
                     (aw_addr_q[5:2] == `OFS_CLOCK_DIV_CTRL >> 2) ||
                     (aw_addr_q[5:2] == `OFS_CLOCK_CONFIG >> 2) ||
                     (aw_addr_q[5:2] == `OFS_CLOCK_STATUS >> 2);
    wire unlock_wr = wr_ctrl && (w_data_q[7:0] == 8'h80);
    wire select_wr = wr_ctrl && !w_data_q[`UNLOCK_BIT];

    // Fuse pin synchroniser, three stages with agreement filter
    always @(posedge aclk)
    begin
        fuse_s1_q <= clock_pin_drive_fuse;
        fuse_s2_q <= fuse_s1_q;
        fuse_s3_q <= fuse_s2_q;
        // Accept a level only once two stages agree
        if (fuse_s2_q == fuse_s3_q)
        begin
            fuse_q <= fuse_s3_q;
        end
    end

    // Clock pin drive: runs through reset, overrides port function
    always @(posedge aclk)
    begin
        if (fuse_q)
        begin
            clock_output_pin_oe <= 1'b1;
            // Divider is held in reset, so toggle here to keep a clock out
            if (!aresetn)
            begin
                clock_output_pin_o <= !clock_output_pin_o;
            end
            else
            begin
                clock_output_pin_o <= div_level;
            end
        end
        else
        begin
            clock_output_pin_o  <= port_pin_out;
            clock_output_pin_oe <= port_pin_oe;
        end
    end

    // AXI write channel capture
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_addr_q     <= 6'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            // Address taken
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            // Data taken
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            // Both present: commit and respond
            if (wr_fire)
            begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end
            // Response taken by the master
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Prescaler control register and unlock window
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            divide_change_unlock_q <= 1'b0;
            unlock_cnt_q           <= 3'h0;
            rst_seen_q             <= 1'b0;
            divide_select_q        <= `SELECT_RST_DIV1;
        end
        else
        begin
            rst_seen_q <= 1'b1;
            // Select reset value caught just after release
            if (!rst_seen_q)
            begin
                divide_select_q <= divide_by_eight_fuse ?
                                   `SELECT_RST_DIV8 : `SELECT_RST_DIV1;
            end
            else if (select_wr && divide_change_unlock_q)
            begin
                // Any defined code accepted; reserved ones dropped
                if (sel_valid(w_data_q[3:0]))
                begin
                    divide_select_q <= w_data_q[3:0];
                end
            end
            // Unlock bit: set only by a lone write, timeout not restarted
            if (divide_change_unlock_q)
            begin
                if (select_wr || unlock_cnt_q == 3'h1)
                begin
                    divide_change_unlock_q <= 1'b0;
                    unlock_cnt_q           <= 3'h0;
                end
                else
                begin
                    unlock_cnt_q <= unlock_cnt_q - 3'h1;
                end
            end
            // Lone unlock write opens the window
            else if (unlock_wr)
            begin
                divide_change_unlock_q <= 1'b1;
                unlock_cnt_q           <= `UNLOCK_CYCLES;
            end
        end
    end

    // Trim and timer configuration registers
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_trim_q <= 8'h00;
            ext_tclk_q <= 1'b0;
        end
        else
        begin
            if (!rst_seen_q)
            begin
                osc_trim_q <= factory_trim;
            end
            else if (wr_trim)
            begin
                // Bit 7 range, bits 6:0 fine tune, passed straight through
                osc_trim_q <= w_data_q[7:0];
            end
            if (wr_cfg)
            begin
                ext_tclk_q <= w_data_q[`EXT_TCLK_BIT];
            end
        end
    end

    // Registered outputs to the clock system
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sys_clk_en                  <= 1'b0;
            osc_trim_o                  <= 8'h00;
            timer_osc_enable            <= 1'b0;
            external_timer_clock_select <= 1'b0;
        end
        else
        begin
            sys_clk_en                  <= div_en;
            osc_trim_o                  <= osc_trim_q;
            timer_osc_enable            <= internal_rc_selected;
            // External timer clock only with the internal RC source
            external_timer_clock_select <= ext_tclk_q & internal_rc_selected;
        end
    end

    // AXI read channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr[5:2])
                    `OFS_OSC_TRIM >> 2:
                        s_axi_rdata <= {24'h000000, osc_trim_q};
                    `OFS_CLOCK_DIV_CTRL >> 2:
                        s_axi_rdata <= {24'h000000, divide_change_unlock_q,
                                        3'h0, divide_select_q};
                    `OFS_CLOCK_CONFIG >> 2:
                        s_axi_rdata <= {31'h00000000, ext_tclk_q};
                    `OFS_CLOCK_STATUS >> 2:
                        s_axi_rdata <= {29'h00000000, internal_rc_selected,
                                        div_busy, divide_change_unlock_q};
                    // Unmapped offset: zero data, slave error
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            // Read data taken by the master
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // system_clock_prescaler_ctrl

// file: bench/prescaler_assertions.sv
// Purpose: Concurrent checks on the prescaler control block ports
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Pin path is not reset, so its drive and port-path checks stay live in reset
`timescale 1ns/1ps

module prescaler_assertions
(
    input logic       aclk,
    input logic       aresetn,
    input logic       s_axi_awvalid,
    input logic       s_axi_awready,
    input logic       s_axi_bvalid,
    input logic       s_axi_arvalid,
    input logic       s_axi_arready,
    input logic       s_axi_rvalid,
    input logic       clock_pin_drive_fuse,
    input logic [7:0] factory_trim,
    input logic       internal_rc_selected,
    input logic       port_pin_out,
    input logic       port_pin_oe,
    input logic       clock_output_pin_o,
    input logic       clock_output_pin_oe,
    input logic [7:0] osc_trim_o,
    input logic       timer_osc_enable,
    input logic       external_timer_clock_select
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [2:0] on_q  = 3'h0;  // Cycles with fuse programmed, saturating
    logic [2:0] off_q = 3'h0;  // Cycles with fuse unprogrammed, saturating

    // Count how long the fuse level has held, past its synchroniser
    always @(posedge aclk)
    begin
        on_q  <= !clock_pin_drive_fuse ? 3'h0 : ((on_q == 3'h7) ? on_q : on_q + 3'h1);
        off_q <= clock_pin_drive_fuse ? 3'h0 : ((off_q == 3'h7) ? off_q : off_q + 3'h1);
    end

    chk_pin_driven:
        assert property (disable iff (1'b0) on_q >= 3'h6 |-> clock_output_pin_oe)
        else $error("clock pin not driven with fuse programmed");
    chk_port_path:
        assert property (disable iff (1'b0) off_q >= 3'h6 |->
            clock_output_pin_oe == $past(port_pin_oe) && clock_output_pin_o == $past(port_pin_out))
        else $error("port drive not passed to pin");
    chk_pin_toggles:
        assert property (on_q == 3'h7 |-> ##[1:600] $changed(clock_output_pin_o))
        else $error("clock pin stopped");
    chk_timer_osc_rc:
        assert property (1'b1 |=> timer_osc_enable == $past(internal_rc_selected))
        else $error("timer oscillator enable not following source");
    chk_ext_needs_rc:
        assert property (!internal_rc_selected |=> !external_timer_clock_select)
        else $error("external timer clock without internal source");
    chk_trim_loaded:
        assert property ($rose(aresetn) |-> ##[1:3] osc_trim_o == factory_trim)
        else $error("factory trim not loaded after reset");
    chk_write_answer:
        assert property (s_axi_awvalid && s_axi_awready |-> ##[0:4] s_axi_bvalid)
        else $error("write response late");
    chk_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
        else $error("read data late");

    cov_ext_clock: cover property (external_timer_clock_select);
    cov_pin_rise: cover property ($rose(clock_output_pin_o));
    cov_port_path: cover property (off_q == 3'h7 && port_pin_out);
endmodule // prescaler_assertions

bind system_clock_prescaler_ctrl prescaler_assertions chk
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .clock_pin_drive_fuse(clock_pin_drive_fuse),
    .factory_trim(factory_trim), .internal_rc_selected(internal_rc_selected),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe),
    .osc_trim_o(osc_trim_o), .timer_osc_enable(timer_osc_enable),
    .external_timer_clock_select(external_timer_clock_select)
);

// file: bench/tb.sv
// Purpose: Self-checking bench for the clock prescaler control block
// Assumes: 20 MHz aclk; bready, rready held high; all strobes set
// Notes:   Scenarios are register call sequences with fixed expectations
`timescale 1ns/1ps

module tb;
    logic        aclk, aresetn, prev;          // Clock, reset, pin history
    logic [5:0]  s_axi_awaddr, s_axi_araddr;   // Addresses
    logic [31:0] s_axi_wdata, s_axi_rdata;     // Data
    logic [1:0]  s_axi_bresp, s_axi_rresp;     // Responses
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        clock_pin_drive_fuse, divide_by_eight_fuse, internal_rc_selected;
    logic        port_pin_out, port_pin_oe, clock_output_pin_o, clock_output_pin_oe;
    logic        sys_clk_en, timer_osc_enable, external_timer_clock_select;
    logic [7:0]  factory_trim, osc_trim_o;     // Trim in and out
    logic [31:0] rdat;                         // Last read data
    logic [1:0]  resp;                         // Last response
    logic [31:0] tv [4] = '{32'h7F, 32'h80, 32'h00, 32'hFF}; // Trim edge values
    int          err_total, n_compared, cyc, p, k;

    system_clock_prescaler_ctrl uut
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
        .clock_pin_drive_fuse(clock_pin_drive_fuse), .divide_by_eight_fuse(divide_by_eight_fuse),
        .factory_trim(factory_trim), .internal_rc_selected(internal_rc_selected),
        .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
        .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe),
        .sys_clk_en(sys_clk_en), .osc_trim_o(osc_trim_o), .timer_osc_enable(timer_osc_enable),
        .external_timer_clock_select(external_timer_clock_select)
    );

    // Free-running 50 ns clock
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Report counts, print verdict, end run
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Cut a hang short
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total++;
            give_verdict();
        end
    end

    // Write: offer address and data, release each when taken, wait response
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask

    // Read: hold address until taken, wait for data
    task automatic rd(input logic [5:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // Read and compare
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        rd(a);
        check(rdat, e);
    endtask

    // Unlock, then write the select code
    task automatic set_div(input logic [3:0] c);
        wr(6'h04, 32'h80);
        wr(6'h04, {28'h0, c});
    endtask

    // Cycles between two enable pulses
    task automatic period(output int n);
        n = 0;
        do @(posedge aclk); while (sys_clk_en !== 1'b1);
        do
        begin
            @(posedge aclk);
            n++;
        end while (sys_clk_en !== 1'b1);
    endtask

    // Hold reset 20 cycles with the given divide-by-eight fuse
    task automatic do_reset(input logic div8);
        aresetn <= 1'b0;
        divide_by_eight_fuse <= div8;
        repeat (19) @(posedge aclk);
        prev = clock_output_pin_o;
        @(posedge aclk);
        check(clock_output_pin_o, {31'h0, !prev});
        check(clock_output_pin_oe, 32'h1);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    // Main sequence
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, port_pin_out, port_pin_oe} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
        {clock_pin_drive_fuse, internal_rc_selected, aresetn} = 3'h6;
        divide_by_eight_fuse = 1'b1;
        factory_trim = 8'hA5;
        do_reset(1'b1);
        rchk(6'h04, 32'h3);
        rchk(6'h00, 32'hA5);
        check(osc_trim_o, 32'hA5);
        for (k = 0; k < 4; k++)           // No nonvolatile writes here
        begin
            wr(6'h00, tv[k]);
            rchk(6'h00, tv[k]);
            check(osc_trim_o, tv[k]);
        end
        // Every valid code divides by two to the code
        for (k = 0; k < 9; k++)
        begin
            set_div(k[3:0]);
            rchk(6'h0C, 32'h6);
            rchk(6'h04, k);
            period(p);
            period(p);
            check(p, 1 << k);
        end
        // Pin carries the divided clock
        set_div(4'h2);
        period(p);
        p = 0;
        prev = clock_output_pin_o;
        repeat (256)
        begin
            @(posedge aclk);
            if (clock_output_pin_o === 1'b1 && prev === 1'b0) p++;
            prev = clock_output_pin_o;
        end
        check(p, 64);
        // Reserved codes leave the factor alone
        for (k = 9; k < 16; k++)
        begin
            set_div(k[3:0]);
            rchk(6'h04, 32'h2);
        end
        period(p);
        check(p, 4);
        // Unlock qualification and time-out
        wr(6'h04, 32'h81);
        wr(6'h04, 32'h5);
        rchk(6'h04, 32'h2);
        wr(6'h04, 32'h80);
        repeat (5) @(posedge aclk);
        wr(6'h04, 32'h5);
        rchk(6'h04, 32'h2);
        rchk(6'h0C, 32'h4);
        set_div(4'h5);
        wr(6'h04, 32'h6);
        rchk(6'h04, 32'h5);
        wr(6'h04, 32'h80);
        wr(6'h04, 32'h80);
        wr(6'h04, 32'h6);
        rchk(6'h04, 32'h5);
        wr(6'h04, 32'h80);
        rchk(6'h04, 32'h85);
        // External timer clock needs the internal source; slow timer osc
        wr(6'h08, 32'h1);
        rchk(6'h08, 32'h1);
        check(external_timer_clock_select, 32'h1);
        internal_rc_selected <= 1'b0;
        repeat (2) @(posedge aclk);
        check(external_timer_clock_select, 32'h0);
        check(timer_osc_enable, 32'h0);
        internal_rc_selected <= 1'b1;
        // Unmapped and read-only places
        wr(6'h10, 32'hFF);
        check(resp, 32'h2);
        rchk(6'h14, 32'h0);
        check(resp, 32'h2);
        wr(6'h0C, 32'hFF);
        rchk(6'h0C, 32'h4);
        // Fuse off hands the pin back to the port
        clock_pin_drive_fuse <= 1'b0;
        port_pin_out <= 1'b1;
        repeat (8) @(posedge aclk);
        check(clock_output_pin_o, 32'h1);
        check(clock_output_pin_oe, 32'h0);
        clock_pin_drive_fuse <= 1'b1;
        do_reset(1'b0);
        rchk(6'h04, 32'h0);
        give_verdict();
    end
endmodule // tb
